// ### tcw_pkg.sv
// package: constants for the timer compare waveform unit
package tcw_pkg;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_COUNT  = 12'h004;
  localparam logic [11:0] OFS_CMP    = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00C;
  localparam logic [11:0] OFS_FORCE  = 12'h010;

  // ----------------------------------------
  // control, status and force field positions
  // ----------------------------------------
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_ACTION_LSB = 2;
  localparam int CTRL_RUN_BIT    = 4;
  localparam int STAT_OVF_BIT    = 0;
  localparam int STAT_CMF_BIT    = 1;
  localparam int STAT_WAVE_BIT   = 2;
  localparam int FORCE_BIT       = 0;

  // ----------------------------------------
  // modes and actions
  // ----------------------------------------
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PHASE  = 2'h1;
  localparam logic [1:0] MODE_CLEAR  = 2'h2;
  localparam logic [1:0] MODE_FAST   = 2'h3;
  localparam logic [1:0] ACT_NONE    = 2'h0;
  localparam logic [1:0] ACT_TOGGLE  = 2'h1;
  localparam logic [1:0] ACT_CLEAR   = 2'h2;
  localparam logic [1:0] ACT_SET     = 2'h3;

  // ----------------------------------------
  // reset values and limits
  // ----------------------------------------
  localparam logic [7:0]  COUNT_MAX   = 8'hFF;
  localparam logic [7:0]  COUNT_ZERO  = 8'h00;
  localparam logic [31:0] PSLVERR_OFF = 32'h0000_0000;

endpackage : tcw_pkg

// ### tcw_sync.sv
// module: two flip-flop synchroniser for one pin level
module tcw_sync
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // level
  input  wire logic din,
  output logic      dout
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb
  begin
    meta_d = din;
    sync_d = meta_q;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q;

endmodule : tcw_sync

// ### tcw_timer.sv
// module: 8-bit timer counter with compare waveform unit and apb registers
//
// Implementation choices: the address map and the APB slave port.

module tcw_timer
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // timer control
  input  wire logic        timer_tick,
  input  wire logic        sync_clear,
  // port pin
  input  wire logic        port_out_value,
  input  wire logic        waveform_pin_direction_bit,
  input  wire logic        pin_in,
  output logic             pin_out,
  output logic             pin_oe_n,
  output logic             pin_level
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [1:0] waveform_mode_select_q;
  logic [1:0] waveform_mode_select_d;
  logic [1:0] compare_output_action_q;
  logic [1:0] compare_output_action_d;
  logic       run_q;
  logic       run_d;
  logic [7:0] counter_value_q;
  logic [7:0] counter_value_d;
  logic [7:0] compare_value_q;
  logic [7:0] compare_value_d;
  logic [7:0] compare_buf_q;
  logic [7:0] compare_buf_d;
  logic       overflow_flag_q;
  logic       overflow_flag_d;
  logic       compare_match_flag_q;
  logic       compare_match_flag_d;
  logic       compare_waveform_bit_q;
  logic       compare_waveform_bit_d;
  logic       match_pend_q;
  logic       match_pend_d;
  logic       block_q;
  logic       block_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic wr_en;
  logic rd_en;
  logic wr_ctrl;
  logic wr_count;
  logic wr_cmp;
  logic wr_stat;
  logic force_compare_strobe;
  logic tick;
  logic pwm_mode;
  logic equal;
  logic match;
  logic at_max;
  logic pin_sync;

  assign wr_en    = psel && penable && pwrite;
  assign rd_en    = psel && !penable && !pwrite;
  assign wr_ctrl  = wr_en && (paddr == tcw_pkg::OFS_CTRL);
  assign wr_count = wr_en && (paddr == tcw_pkg::OFS_COUNT);
  assign wr_cmp   = wr_en && (paddr == tcw_pkg::OFS_CMP);
  assign wr_stat  = wr_en && (paddr == tcw_pkg::OFS_STATUS);
  assign force_compare_strobe = wr_en && (paddr == tcw_pkg::OFS_FORCE)
                                && pwdata[tcw_pkg::FORCE_BIT];
  assign pready   = 1'b1;
  assign pslverr  = 1'b0;
  assign prdata   = prdata_q;

  assign tick     = timer_tick && run_q;
  assign pwm_mode = waveform_mode_select_q[0];
  assign at_max   = counter_value_q == tcw_pkg::COUNT_MAX;
  assign equal    = counter_value_q == compare_value_q;
  assign match    = equal && !block_q;

  // ----------------------------------------
  // pin input synchroniser
  // ----------------------------------------
  tcw_sync u_pin_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (pin_in),
    .dout    (pin_sync)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    waveform_mode_select_d  = waveform_mode_select_q;
    compare_output_action_d = compare_output_action_q;
    run_d                   = run_q;
    counter_value_d         = counter_value_q;
    compare_value_d         = compare_value_q;
    compare_buf_d           = compare_buf_q;
    overflow_flag_d         = overflow_flag_q;
    compare_match_flag_d    = compare_match_flag_q;
    compare_waveform_bit_d  = compare_waveform_bit_q;
    match_pend_d            = match_pend_q;
    block_d                 = block_q;
    prdata_d                = prdata_q;

    // control writes
    if (wr_ctrl)
    begin
      waveform_mode_select_d  = pwdata[tcw_pkg::CTRL_MODE_LSB +: 2];
      compare_output_action_d = pwdata[tcw_pkg::CTRL_ACTION_LSB +: 2];
      run_d                   = pwdata[tcw_pkg::CTRL_RUN_BIT];
    end

    // compare writes
    if (wr_cmp)
    begin
      compare_buf_d = pwdata[7:0];
      if (!pwm_mode)
      begin
        compare_value_d = pwdata[7:0];
      end
    end

    // status clear by writing one; hardware sets below win
    if (wr_stat && pwdata[tcw_pkg::STAT_OVF_BIT])
    begin
      overflow_flag_d = 1'b0;
    end
    if (wr_stat && pwdata[tcw_pkg::STAT_CMF_BIT])
    begin
      compare_match_flag_d = 1'b0;
    end

    // timer clock step
    if (tick)
    begin
      block_d      = 1'b0;
      match_pend_d = match;
      if (match_pend_q)
      begin
        compare_match_flag_d = 1'b1;
      end
      case (waveform_mode_select_q)
        tcw_pkg::MODE_NORMAL:
        begin
          counter_value_d = counter_value_q + 8'h01;
          if (at_max)
          begin
            overflow_flag_d = 1'b1;
          end
        end
        tcw_pkg::MODE_CLEAR:
        begin
          if (match)
          begin
            counter_value_d = tcw_pkg::COUNT_ZERO;
          end
          else
          begin
            counter_value_d = counter_value_q + 8'h01;
          end
          if (at_max)
          begin
            overflow_flag_d = 1'b1;
          end
        end
        tcw_pkg::MODE_FAST:
        begin
          counter_value_d = counter_value_q + 8'h01;
          if (at_max)
          begin
            overflow_flag_d = 1'b1;
            compare_value_d = compare_buf_q;
          end
        end
        default:
        begin
          counter_value_d = counter_value_q + 8'h01;
        end
      endcase

      // waveform action on match outside phase mode, and at the counter top in fast mode with clear or set
      if (!pwm_mode && match)
      begin
        case (compare_output_action_q)
          tcw_pkg::ACT_TOGGLE: compare_waveform_bit_d = !compare_waveform_bit_q;
          tcw_pkg::ACT_CLEAR:  compare_waveform_bit_d = 1'b0;
          tcw_pkg::ACT_SET:    compare_waveform_bit_d = 1'b1;
          default:             compare_waveform_bit_d = compare_waveform_bit_q;
        endcase
      end
      else if (waveform_mode_select_q == tcw_pkg::MODE_FAST)
      begin
        case (compare_output_action_q)
          tcw_pkg::ACT_CLEAR:
          begin
            if (match)
            begin
              compare_waveform_bit_d = 1'b0;
            end
            else if (at_max)
            begin
              compare_waveform_bit_d = 1'b1;
            end
          end
          tcw_pkg::ACT_SET:
          begin
            if (match)
            begin
              compare_waveform_bit_d = 1'b1;
            end
            else if (at_max)
            begin
              compare_waveform_bit_d = 1'b0;
            end
          end
          tcw_pkg::ACT_TOGGLE:
          begin
            if (match)
            begin
              compare_waveform_bit_d = !compare_waveform_bit_q;
            end
          end
          default:
          begin
            compare_waveform_bit_d = compare_waveform_bit_q;
          end
        endcase
      end
    end

    // force strobe, non-pwm only
    if (force_compare_strobe && !pwm_mode)
    begin
      case (compare_output_action_q)
        tcw_pkg::ACT_TOGGLE: compare_waveform_bit_d = !compare_waveform_bit_q;
        tcw_pkg::ACT_CLEAR:  compare_waveform_bit_d = 1'b0;
        tcw_pkg::ACT_SET:    compare_waveform_bit_d = 1'b1;
        default:             compare_waveform_bit_d = compare_waveform_bit_q;
      endcase
    end

    // counter write wins and blocks next match
    if (wr_count)
    begin
      counter_value_d = pwdata[7:0];
      block_d         = 1'b1;
      match_pend_d    = 1'b0;
    end

    // read data
    if (rd_en)
    begin
      case (paddr)
        tcw_pkg::OFS_CTRL:   prdata_d = {27'h0, run_q, compare_output_action_q,
                                         waveform_mode_select_q};
        tcw_pkg::OFS_COUNT:  prdata_d = {24'h0, counter_value_q};
        tcw_pkg::OFS_CMP:    prdata_d = {24'h0, compare_buf_q};
        tcw_pkg::OFS_STATUS: prdata_d = {28'h0, pin_sync, compare_waveform_bit_q,
                                         compare_match_flag_q, overflow_flag_q};
        default:             prdata_d = tcw_pkg::PSLVERR_OFF;
      endcase
    end

    // synchronous clear
    if (sync_clear)
    begin
      counter_value_d        = tcw_pkg::COUNT_ZERO;
      overflow_flag_d        = 1'b0;
      compare_match_flag_d   = 1'b0;
      compare_waveform_bit_d = 1'b0;
      match_pend_d           = 1'b0;
      block_d                = 1'b0;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      waveform_mode_select_q  <= tcw_pkg::MODE_NORMAL;
      compare_output_action_q <= tcw_pkg::ACT_NONE;
      run_q                   <= 1'b0;
      counter_value_q         <= tcw_pkg::COUNT_ZERO;
      compare_value_q         <= tcw_pkg::COUNT_ZERO;
      compare_buf_q           <= tcw_pkg::COUNT_ZERO;
      overflow_flag_q         <= 1'b0;
      compare_match_flag_q    <= 1'b0;
      compare_waveform_bit_q  <= 1'b0;
      match_pend_q            <= 1'b0;
      block_q                 <= 1'b0;
      prdata_q                <= tcw_pkg::PSLVERR_OFF;
    end
    else
    begin
      waveform_mode_select_q  <= waveform_mode_select_d;
      compare_output_action_q <= compare_output_action_d;
      run_q                   <= run_d;
      counter_value_q         <= counter_value_d;
      compare_value_q         <= compare_value_d;
      compare_buf_q           <= compare_buf_d;
      overflow_flag_q         <= overflow_flag_d;
      compare_match_flag_q    <= compare_match_flag_d;
      compare_waveform_bit_q  <= compare_waveform_bit_d;
      match_pend_q            <= match_pend_d;
      block_q                 <= block_d;
      prdata_q                <= prdata_d;
    end
  end

  // ----------------------------------------
  // pin override
  // ----------------------------------------
  always_comb
  begin
    pin_out   = (compare_output_action_q != tcw_pkg::ACT_NONE) ? compare_waveform_bit_q
                                                               : port_out_value;
    pin_oe_n  = !waveform_pin_direction_bit;
    pin_level = pin_sync;
  end

endmodule : tcw_timer

// ### tcw_pin_model.sv
// partner model: the port pin wire and an outside driver
module tcw_pin_model
(
  // design side
  input  wire logic pclk,
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  // outside driver
  input  wire logic ext_en,
  input  wire logic ext_val,
  output logic      pin_in
);
  logic flip_q = 1'b0;

  always_ff @(posedge pclk) flip_q <= !flip_q;
  // design drives while enable is low, else outside driver or a floating pattern
  always_comb pin_in = !pin_oe_n ? pin_out : (ext_en ? ext_val : flip_q);
endmodule : tcw_pin_model

// ### tcw_timer_assertions.sv
// checker: port-level assertions for the timer compare waveform unit
module tcw_timer_assertions
(
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // timer
  input wire logic        timer_tick,
  input wire logic        sync_clear,
  // pin
  input wire logic        port_out_value,
  input wire logic        waveform_pin_direction_bit,
  input wire logic        pin_in,
  input wire logic        pin_out,
  input wire logic        pin_oe_n,
  input wire logic        pin_level
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic       wr;
  logic       rd;
  logic [4:0] ctl_d;
  logic [4:0] ctl_q;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  always_comb ctl_d = (wr && paddr == tcw_pkg::OFS_CTRL) ? pwdata[4:0] : ctl_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) ctl_q <= 5'h00;
    else ctl_q <= ctl_d;

  sequence s_quiet;
    !timer_tick && !wr && !sync_clear;
  endsequence
  sequence s_clear3;
    (sync_clear && timer_tick) [*3];
  endsequence

  a_oe_follows_dir: assert property (pin_oe_n == !waveform_pin_direction_bit)
    else $error("pin enable does not follow direction");
  a_ready_no_err: assert property (pready && !pslverr)
    else $error("apb answer not ready or error");
  a_port_override: assert property (ctl_q[3:2] == tcw_pkg::ACT_NONE |-> pin_out == port_out_value)
    else $error("pin not port value with action none");
  a_wave_stable: assert property (ctl_q[3:2] != 2'h0 ##0 s_quiet |=> $stable(pin_out))
    else $error("waveform pin changed without cause");
  a_read_ctrl: assert property (rd && paddr == tcw_pkg::OFS_CTRL |-> prdata[4:0] == ctl_q)
    else $error("control readback wrong");
  a_unmapped_read: assert property (rd && paddr >= 12'h014 |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_clear_wave: assert property (s_clear3 |-> ctl_q[3:2] == 2'h0 || !pin_out)
    else $error("waveform bit not cleared");
  a_level_sync: assert property ($stable(pin_in) [*3] |-> pin_level == pin_in)
    else $error("pin level not synchronised");
endmodule : tcw_timer_assertions

bind tcw_timer tcw_timer_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .timer_tick(timer_tick), .sync_clear(sync_clear),
  .port_out_value(port_out_value), .waveform_pin_direction_bit(waveform_pin_direction_bit),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_level(pin_level));

// ### testbench.sv
// testbench: self-checking bench for the timer compare waveform unit
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        timer_tick, sync_clear, port_out_value, dir_bit, ext_en, ext_val;
  logic        pin_in, pin_out, pin_oe_n, pin_level;
  logic [7:0]  m_cnt, m_cmp, m_buf;
  logic [1:0]  m_mode, m_act;
  logic        m_ovf, m_cmf, m_pend, m_wave, m_blk;
  int          n_errors, num_checks, cyc, k;

  tcw_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_tick(timer_tick), .sync_clear(sync_clear),
    .port_out_value(port_out_value), .waveform_pin_direction_bit(dir_bit),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_level(pin_level));
  tcw_pin_model u_pin (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = !pclk;
  end

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_errors++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // tasks and model
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  function automatic logic apply(logic w, logic [1:0] a);
    return a == 2'h1 ? !w : a == 2'h2 ? 1'b0 : a == 2'h3 ? 1'b1 : w;
  endfunction : apply

  task automatic ref_tick();
    logic hit;
    hit = m_cnt == m_cmp && !m_blk;
    m_blk = 1'b0;
    if (m_pend) m_cmf = 1'b1;
    m_pend = hit;
    if (hit && m_mode != 2'h1) m_wave = apply(m_wave, m_act);
    if (m_cnt == 8'hFF)
    begin
      if (m_mode != 2'h1) m_ovf = 1'b1;
      if (m_mode == 2'h3) m_cmp = m_buf;
      if (m_mode == 2'h3 && m_act[1] && !hit) m_wave = !m_act[0];
    end
    if (m_mode == 2'h2 && hit) m_cnt = 8'h00;
    else m_cnt = m_cnt + 8'h01;
  endtask : ref_tick

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic rd_chk(input string n, input logic [11:0] a, input logic [31:0] e,
                        input logic [31:0] m);
    logic [31:0] r;
    apb(1'b0, a, 32'h0000_0000, r);
    chk(n, e, r & m);
  endtask : rd_chk

  task automatic chk_state();
    rd_chk("count", tcw_pkg::OFS_COUNT, {24'h0, m_cnt}, '1);
    rd_chk("status", tcw_pkg::OFS_STATUS, {29'h0, m_wave, m_cmf, m_ovf}, 32'h7);
  endtask : chk_state

  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge pclk);
      timer_tick <= 1'b1;
      @(posedge pclk);
      timer_tick <= 1'b0;
      ref_tick();
    end
  endtask : tick

  task automatic cfg(input logic [1:0] md, input logic [1:0] ac);
    wr(tcw_pkg::OFS_CTRL, {27'h0, 1'b1, ac, md});
    m_mode = md;
    m_act = ac;
  endtask : cfg

  task automatic set_cmp(input logic [7:0] v);
    wr(tcw_pkg::OFS_CMP, {24'h0, v});
    m_buf = v;
    if (m_mode != 2'h3) m_cmp = v;
  endtask : set_cmp

  task automatic set_cnt(input logic [7:0] v);
    wr(tcw_pkg::OFS_COUNT, {24'h0, v});
    m_cnt = v;
    m_blk = 1'b1;
    m_pend = 1'b0;
  endtask : set_cnt

  task automatic force_wave();
    wr(tcw_pkg::OFS_FORCE, 32'h0000_0001);
    if (!m_mode[0]) m_wave = apply(m_wave, m_act);
  endtask : force_wave

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {presetn, psel, penable, pwrite, timer_tick, sync_clear, dir_bit, ext_val} = '0;
    {paddr, pwdata, port_out_value, ext_en} = '0;
    {m_cnt, m_cmp, m_buf, m_mode, m_act, m_ovf, m_cmf, m_pend, m_wave, m_blk} = '0;
    {n_errors, num_checks, cyc} = '0;
    ext_en = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(32'h22a663db));
    for (int i = 0; i < 6; i++)
      rd_chk("reset", 12'(4 * i), 32'h0000_0000, '1);
    wr(12'hFFC, '1);
    rd_chk("unmapped", 12'hFFC, 32'h0000_0000, '1);
    $display("test registers done");
    cfg(tcw_pkg::MODE_NORMAL, tcw_pkg::ACT_NONE);
    set_cnt(8'hFE);
    tick(2);
    chk_state();
    $display("test normal wrap done");
    cfg(tcw_pkg::MODE_CLEAR, tcw_pkg::ACT_TOGGLE);
    set_cmp(8'h00);
    set_cnt(8'hFF);
    repeat (4)
    begin
      tick(1);
      chk_state();
    end
    set_cnt(8'h14);
    set_cmp(8'h0A);
    tick(250);
    chk_state();
    $display("test clear on match done");
    for (int a = 2; a < 4; a++)
    begin
      cfg(tcw_pkg::MODE_FAST, 2'(a));
      set_cmp(a == 2 ? 8'h00 : 8'h50);
      repeat (8)
      begin
        tick($urandom_range(1, 64));
        chk_state();
      end
    end
    cfg(tcw_pkg::MODE_FAST, tcw_pkg::ACT_SET);
    set_cmp(8'hFF);
    tick(300);
    chk_state();
    $display("test fast pwm done");
    for (int a = 0; a < 4; a++)
    begin
      cfg(tcw_pkg::MODE_NORMAL, 2'(a));
      port_out_value <= 1'($urandom);
      force_wave();
      chk_state();
      dir_bit <= 1'b1;
      repeat (4) @(posedge pclk);
      chk("pin", {31'h0, a == 0 ? port_out_value : m_wave}, {31'h0, pin_level});
      dir_bit <= 1'b0;
    end
    $display("test force and pin done");
    repeat (6)
    begin
      k = $urandom_range(0, 2);
      cfg(k == 0 ? 2'h0 : k == 1 ? 2'h2 : 2'h3, 2'($urandom));
      set_cmp(8'($urandom_range(0, 254)));
      set_cnt(8'($urandom));
      if ($urandom_range(0, 1)) force_wave();
      if ($urandom_range(0, 1))
      begin
        wr(tcw_pkg::OFS_STATUS, 32'h0000_0003);
        {m_ovf, m_cmf} = 2'b00;
      end
      ext_val <= 1'($urandom);
      tick($urandom_range(1, 600));
      chk_state();
      rd_chk("cmp", tcw_pkg::OFS_CMP, {24'h0, m_buf}, '1);
    end
    $display("test random done");
    @(posedge pclk);
    sync_clear <= 1'b1;
    timer_tick <= 1'b1;
    repeat (3) @(posedge pclk);
    sync_clear <= 1'b0;
    timer_tick <= 1'b0;
    {m_cnt, m_ovf, m_cmf, m_pend, m_wave, m_blk} = '0;
    chk_state();
    $display("test sync clear done");
    report_and_stop();
  end
endmodule : testbench
